// ===== hdl/pced_pkg.sv
// Purpose: Shared types and constants of the end delimiter checker.
// Assumes: One classified symbol per enabled clock while a frame runs.
// Notes: Symbol classes come from the upstream decoder on the same clock.
`default_nettype none
package pced_pkg;

  // Class of a received symbol as handed over by the decoder.
  typedef enum logic [3:0] {
    sk_idle,
    sk_ssd,
    sk_pre,
    sk_data,
    sk_esd1,
    sk_esd2,
    sk_esd3,
    sk_err_esd3,
    sk_other
  } pced_sym_t;

  // States of the receive sequencer.
  typedef enum logic [3:0] {
    st_idle,
    st_ssd2,
    st_ssd3,
    st_stream,
    await_second_end_delim,
    await_third_end_delim,
    st_esd_end,
    bad_end_recovery,
    receive_error_state
  } pced_state_t;

  // Nibble shown on the receive data lines during preamble.
  localparam logic [3:0] PRE_NIB = 4'h5;
  // Nibble shown while the frame is not valid or is in error.
  localparam logic [3:0] IDLE_NIB = 4'h0;
  // Values after reset.
  localparam pced_state_t RST_STATE = st_idle;
  localparam logic [3:0] RST_NIB = 4'h0;
  localparam logic RST_FLAG = 1'b0;

endpackage
`default_nettype wire

// ===== hdl/pced_emit_if.sv
// Purpose: Carries one output slot from the sequencer to the MII stage.
// Assumes: Source and sink share one clock.
// Notes: A slot is taken only while stb is high.
`timescale 1ns/100ps
`default_nettype none
interface pced_emit_if;
  logic stb;
  logic dv;
  logic er;
  logic [3:0] nib;
  modport src (output stb, output dv, output er, output nib);
  modport dst (input stb, input dv, input er, input nib);
endinterface
`default_nettype wire

// ===== hdl/pced_mii_out.sv
// Purpose: Registers the receive data valid, data and error lines.
// Assumes: Slots arrive on the emit interface from the sequencer.
// Notes: Outputs hold their value between slots.
`timescale 1ns/100ps
`default_nettype none
module pced_mii_out (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  pced_emit_if.dst emit,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd
);
  import pced_pkg::*;

  typedef struct packed {
    logic dv;
    logic er;
    logic [3:0] nib;
  } pced_out_t;

  pced_out_t cur_q;
  pced_out_t cur_d;

  // Take a new slot when one is offered, otherwise hold.
  always_comb begin
    cur_d = cur_q;
    if (emit.stb) begin
      cur_d.dv = emit.dv;
      cur_d.er = emit.er;
      cur_d.nib = emit.nib;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_q <= '{dv: RST_FLAG, er: RST_FLAG, nib: RST_NIB};
    end else if (ce) begin
      cur_q <= cur_d;
    end
  end

  // The lines come straight from the flip-flops.
  assign rx_dv = cur_q.dv;
  assign rx_er = cur_q.er;
  assign rxd = cur_q.nib;

  // A taken slot shows on the lines one edge later.
  slot_shown_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && emit.stb) |=> (rx_dv == $past(emit.dv) && rxd == $past(emit.nib)
      && rx_er == $past(emit.er)))
    else $error("Output slot not shown on the lines.");

endmodule
`default_nettype wire

// ===== hdl/pced_rx_seq.sv
// Purpose: Receive sequencer that checks the end delimiters of a frame.
// Assumes: sym_valid marks one classified symbol per enabled clock.
// Notes: Each symbol's output slot is shown one symbol later, so that an
// end delimiter can be judged by the symbol that follows it.
//
// Notes on behaviour
// - In the await-second state an ESD2 moves on to the await-third state.
// - In the await-second state anything but ESD2 goes to bad end recovery.
// - In the await-third state an ESD3 ends the frame normally.
// - In the await-third state an ERR ESD3 goes to the receive error state.
// - In the await-third state any other symbol goes to bad end recovery.
// - A good stream shows six preamble nibbles with valid set, then data.
// - After ESD1, ESD2 and ESD3 the valid line drops and data reads zero.
// - A short preamble, ESD1 and a non-ESD2 give four preamble then error.
// - ESD1, ESD2 and a bad third symbol give five preamble then error.
// - A repeated ESD2 where ESD3 is due is a bad end and flags an error.
// - The data state is kept, passing nibbles, until ESD1 arrives.
// - Bad end recovery and receive error flag an error, then go idle.
`timescale 1ns/100ps
`default_nettype none
module pced_rx_seq (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic sym_valid,
  input wire pced_pkg::pced_sym_t sym_kind,
  input wire logic [3:0] sym_nib,
  output logic rx_dv,
  output logic rx_er,
  output logic [3:0] rxd,
  output logic frame_active
);
  import pced_pkg::*;

  typedef struct packed {
    pced_state_t state;
    logic [3:0] pend_nib;
    logic data_seen;
  } pced_seq_t;

  pced_seq_t seq_q;
  pced_seq_t seq_d;
  logic stb;
  logic emit_dv;
  logic emit_er;
  logic [3:0] emit_nib;

  pced_emit_if emit_if ();

  // Nibble carried by a stream symbol; preamble is a fixed pattern.
  function automatic logic [3:0] slot_nib(input pced_sym_t k,
                                          input logic [3:0] n);
    slot_nib = (k == sk_pre) ? PRE_NIB : n;
  endfunction

  assign stb = ce && sym_valid;

  // Next state and the output slot of the previous symbol.
  always_comb begin
    seq_d = seq_q;
    emit_dv = 1'b0;
    emit_er = 1'b0;
    emit_nib = IDLE_NIB;
    if (sym_valid) begin
      case (seq_q.state)
        st_idle: begin
          seq_d.data_seen = 1'b0;
          if (sym_kind == sk_ssd) begin
            seq_d.state = st_ssd2;
          end
        end
        st_ssd2: begin
          seq_d.state = (sym_kind == sk_ssd) ? st_ssd3 : st_idle;
        end
        st_ssd3: begin
          // The third SSD opens the stream with the first preamble slot.
          if (sym_kind == sk_ssd) begin
            seq_d.state = st_stream;
            seq_d.pend_nib = PRE_NIB;
          end else begin
            seq_d.state = st_idle;
          end
        end
        st_stream: begin
          // Release the held nibble and hold the new one until ESD1.
          emit_dv = 1'b1;
          emit_nib = seq_q.pend_nib;
          if (sym_kind == sk_esd1) begin
            seq_d.state = await_second_end_delim;
          end else begin
            seq_d.pend_nib = slot_nib(sym_kind, sym_nib);
            if (sym_kind != sk_pre) begin
              seq_d.data_seen = 1'b1;
            end
          end
        end
        await_second_end_delim: begin
          // The ESD1 slot is judged by the symbol after it.
          if (sym_kind == sk_esd2) begin
            seq_d.state = await_third_end_delim;
            emit_dv = !seq_q.data_seen;
            emit_nib = seq_q.data_seen ? IDLE_NIB : PRE_NIB;
          end else begin
            seq_d.state = bad_end_recovery;
            emit_dv = 1'b1;
            emit_er = 1'b1;
          end
        end
        await_third_end_delim: begin
          if (sym_kind == sk_esd3) begin
            seq_d.state = st_esd_end;
            emit_nib = IDLE_NIB;
          end else if (sym_kind == sk_err_esd3) begin
            seq_d.state = receive_error_state;
            emit_dv = 1'b1;
            emit_er = 1'b1;
          end else begin
            // A second ESD2 lands here as well and counts as a bad end.
            seq_d.state = bad_end_recovery;
            emit_dv = 1'b1;
            emit_er = 1'b1;
          end
        end
        st_esd_end: begin
          seq_d.state = st_idle;
        end
        bad_end_recovery, receive_error_state: begin
          // Flag the error for this slot, whatever arrives.
          seq_d.state = st_idle;
          emit_dv = 1'b1;
          emit_er = 1'b1;
        end
        default: begin
          seq_d.state = st_idle;
        end
      endcase
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_q <= '{state: RST_STATE, pend_nib: RST_NIB, data_seen: RST_FLAG};
    end else if (ce) begin
      seq_q <= seq_d;
    end
  end

  // Hand each slot to the output stage.
  assign emit_if.stb = sym_valid;
  assign emit_if.dv = emit_dv;
  assign emit_if.er = emit_er;
  assign emit_if.nib = emit_nib;

  // The frame is open from the first SSD until idle is reached.
  assign frame_active = (seq_q.state != st_idle);

  pced_mii_out u_out (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .emit(emit_if.dst),
    .rx_dv(rx_dv),
    .rx_er(rx_er),
    .rxd(rxd)
  );

  // Steps of the stream opening and the end delimiter check.
  sequence s_esd1;
    stb && seq_q.state == st_stream && sym_kind == sk_esd1;
  endsequence

  sequence s_in_a2;
    stb && seq_q.state == await_second_end_delim;
  endsequence

  sequence s_in_a3;
    stb && seq_q.state == await_third_end_delim;
  endsequence

  sequence s_open;
    stb && seq_q.state == st_ssd3 && sym_kind == sk_ssd;
  endsequence

  a2_esd2_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_in_a2 ##0 (sym_kind == sk_esd2) |=>
      seq_q.state == await_third_end_delim)
    else $error("ESD2 did not lead to the third delimiter check.");

  a2_bad_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_in_a2 ##0 (sym_kind != sk_esd2) |=>
      seq_q.state == bad_end_recovery)
    else $error("Bad second delimiter not sent to recovery.");

  a3_good_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_in_a3 ##0 (sym_kind == sk_esd3) |=> seq_q.state == st_esd_end)
    else $error("ESD3 did not end the frame.");

  a3_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_in_a3 ##0 (sym_kind == sk_err_esd3) |=>
      seq_q.state == receive_error_state)
    else $error("ERR ESD3 did not reach the error state.");

  a3_bad_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_in_a3 ##0 (sym_kind != sk_esd3 && sym_kind != sk_err_esd3) |=>
      seq_q.state == bad_end_recovery)
    else $error("Bad third delimiter not sent to recovery.");

  pre_open_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_open ##1 (stb && seq_q.state == st_stream) |->
      emit_dv && !emit_er && emit_nib == PRE_NIB)
    else $error("Stream did not open with a preamble nibble.");

  clean_end_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_in_a3 ##0 (sym_kind == sk_esd3) |=> (ce |-> ##1
      (!rx_dv && !rx_er && rxd == IDLE_NIB)))
    else $error("Valid or data not cleared after a good end.");

  short_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_esd1 ##1 (stb && sym_kind != sk_esd2) |-> emit_er && emit_dv)
    else $error("Missing ESD2 not flagged.");

  late_pre_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_esd1 ##1 (stb && sym_kind == sk_esd2 && !seq_q.data_seen) |->
      (emit_dv && !emit_er && emit_nib == PRE_NIB))
    else $error("Fifth preamble slot after ESD2 missing.");

  // The slot after ESD2 is an error unless ESD3 follows it.
  late_err_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_esd1 ##1 (stb && sym_kind == sk_esd2) ##1
      (stb && sym_kind != sk_esd3) |-> (emit_dv && emit_er))
    else $error("Bad third delimiter not flagged.");

  rep_esd2_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_in_a3 ##0 (sym_kind == sk_esd2) |-> emit_er ##1
      seq_q.state == bad_end_recovery)
    else $error("Repeated ESD2 not treated as a bad end.");

  data_stay_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stb && seq_q.state == st_stream && sym_kind != sk_esd1) |=>
      seq_q.state == st_stream)
    else $error("Data state left without ESD1.");

  recover_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stb && (seq_q.state == bad_end_recovery ||
      seq_q.state == receive_error_state)) |-> emit_er ##1
      seq_q.state == st_idle)
    else $error("Error state did not flag and return to idle.");

  esd1_move_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_esd1 |=> seq_q.state == await_second_end_delim)
    else $error("ESD1 did not start the delimiter check.");

  end_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    (stb && seq_q.state == st_esd_end) |-> !emit_dv && !emit_er ##1
      seq_q.state == st_idle)
    else $error("Normal end did not return cleanly to idle.");

endmodule
`default_nettype wire

// ===== sim/pced_line_model.sv
// Purpose: Far-end model that hands classified symbols to the sequencer.
// Assumes: Symbols change 2 ns after the rising clock edge.
// Notes: Between symbols the line carries no meaning, so it is scrambled.
`timescale 1ns/100ps
`default_nettype none
module pced_line_model (
  input wire logic clk,
  output logic sym_valid,
  output var pced_pkg::pced_sym_t sym_kind,
  output logic [3:0] sym_nib
);
  import pced_pkg::*;

  // Line starts released until the first frame.
  initial begin
    sym_valid = 1'b0;
    sym_kind = sk_idle;
    sym_nib = 4'h0;
  end

  // Puts one symbol on the line for exactly one rising edge.
  task automatic send(input byte c, input logic [3:0] n);
    sym_valid = 1'b1;
    sym_nib = (c == "D") ? n : ~sym_nib;
    case (c)
      "S": sym_kind = sk_ssd;
      "P": sym_kind = sk_pre;
      "D": sym_kind = sk_data;
      "1": sym_kind = sk_esd1;
      "2": sym_kind = sk_esd2;
      "3": sym_kind = sk_esd3;
      "R": sym_kind = sk_err_esd3;
      "X": sym_kind = sk_other;
      default: sym_kind = sk_idle;
    endcase
    @(posedge clk);
    #2;
  endtask

  // Releases the line for one cycle; kind and nibble must be ignored.
  task automatic gap();
    sym_valid = 1'b0;
    sym_kind = sk_other;
    sym_nib = ~sym_nib;
    @(posedge clk);
    #2;
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the end delimiter sequencer.
// Assumes: Each output slot shows one taken symbol after its own symbol.
// Notes: Row letters: S ssd, P pre, D data, 1 2 3 end marks, R err end,
// X other, I idle, g line released, c end mark with ce low.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pced_pkg::*;

  typedef struct {
    string syms;
    string exp;
  } pced_row_t;

  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ce = 1'b1;
  logic sym_valid;
  pced_sym_t sym_kind;
  logic [3:0] sym_nib;
  logic rx_dv;
  logic rx_er;
  logic [3:0] rxd;
  logic frame_active;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;

  // Expected: . idle, p preamble, d data nibble, e error slot.
  pced_row_t rows [8] = '{
    '{"SSSPPPPPDD123I", "...ppppppdd..."},
    '{"SSSPPgPPPDcD12g3I", "...ppppppppdd...."},
    '{"SSSPPP1XII", "...ppppee."},
    '{"SSSPPP13II", "...ppppee."},
    '{"SSSPPP12RII", "...pppppee."},
    '{"SSSPPP12XII", "...pppppee."},
    '{"SSSPPP1223II", "...pppppee.."},
    '{"SSSPPPDD12XII", "...ppppdd.ee."}
  };

  pced_rx_seq u_pced_rx_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .sym_valid(sym_valid),
    .sym_kind(sym_kind),
    .sym_nib(sym_nib),
    .rx_dv(rx_dv),
    .rx_er(rx_er),
    .rxd(rxd),
    .frame_active(frame_active)
  );

  pced_line_model u_line (
    .clk(clk),
    .sym_valid(sym_valid),
    .sym_kind(sym_kind),
    .sym_nib(sym_nib)
  );

  // Clock of 50 ns period.
  always #25 clk = ~clk;

  // Cuts a hang short well past the length of all tests.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      miscompares++;
      $display("BAD %0t run timed out", $time);
      final_report();
    end
  end

  // Compares the three receive lines.
  task automatic chk_mii(input logic dv, input logic er, input logic [3:0] n);
    checks++;
    if (rx_dv !== dv || rx_er !== er || rxd !== n) begin
      miscompares++;
      $display("BAD %0t mii got %b %b %h want %b %b %h", $time,
               rx_dv, rx_er, rxd, dv, er, n);
    end
  endtask

  // Compares the frame status flag.
  task automatic chk_act(input logic a);
    checks++;
    if (frame_active !== a) begin
      miscompares++;
      $display("BAD %0t frame_active got %b want %b", $time, frame_active, a);
    end
  endtask

  // Turns one expected letter into a comparison.
  task automatic check_slot(input byte e, input logic [3:0] dn);
    case (e)
      "p": chk_mii(1'b1, 1'b0, PRE_NIB);
      "d": chk_mii(1'b1, 1'b0, dn);
      "e": chk_mii(1'b1, 1'b1, IDLE_NIB);
      default: chk_mii(1'b0, 1'b0, IDLE_NIB);
    endcase
  endtask

  // Sends one row a symbol per cycle and checks every visible slot.
  task automatic run_row(input pced_row_t r);
    logic [3:0] prev;
    logic [3:0] cur;
    prev = 4'h0;
    for (int i = 0; i < r.syms.len(); i++) begin
      cur = 4'h9 ^ i[3:0];
      if (r.syms[i] == "g") begin
        u_line.gap();
      end else begin
        ce = (r.syms[i] != "c");
        u_line.send((r.syms[i] == "c") ? "1" : r.syms[i], cur);
        ce = 1'b1;
      end
      check_slot(r.exp[i], prev);
      if (r.syms[i] == "D") begin
        prev = cur;
      end
    end
  endtask

  // Prints the verdict and ends the run.
  task automatic final_report();
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Reset, the row table, then a reset in mid-frame.
  initial begin
    repeat (12) @(posedge clk);
    #2;
    chk_mii(1'b0, 1'b0, RST_NIB);
    chk_act(RST_FLAG);
    sys_rst = 1'b0;
    foreach (rows[k]) begin
      run_row(rows[k]);
      chk_act(1'b0);
    end
    run_row('{"SSSPPP1", "...pppp"});
    chk_act(1'b1);
    sys_rst = 1'b1;
    #1;
    chk_mii(1'b0, 1'b0, RST_NIB);
    chk_act(RST_FLAG);
    @(posedge clk);
    #2;
    sys_rst = 1'b0;
    run_row(rows[0]);
    chk_act(1'b0);
    final_report();
  end
endmodule
`default_nettype wire
